// ===== core/ghpi_device.sv
// Purpose: device end of the host pin interface and controller pins
// Assumes: bus pins from the host arrive asynchronously
// Notes: GPIB side is reduced to state inputs and pin outputs
// How it works
// - controller pin low while active or standby
// - active drives ATN, standby releases it
// - status bit 0 reports controller state
// - select lines plus page choose register
// - grant or no chip enable masks select
// - host reads with strobe idle, direction high
// - write captured at strobe trailing edge
// - DMA read with direction low presents data-in
// - DMA write strobe ignored when direction low
// - pin bus bit-reversed against register bits
// - grant routes DMA, drops DMA request
// - interrupt only pulled low, never high
// - trigger while device trigger active
// - trigger pulse on trigger aux command
// - reset gives native mode, idle functions
// - power-on message held until cleared
// - reset acts asynchronously
`timescale 1ns/1ps
`default_nettype none
module ghpi_device
	import ghpi_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	ghpi_if.dev pins,
	input wire logic parallel_poll_active,
	input wire logic source_idle,
	input wire logic device_trigger_active,
	input wire logic ifc_received,
	input wire logic control_received,
	input wire logic [ghpi_pkg::DW-1:0] data_in_byte,
	input wire logic data_in_valid,
	input wire logic out_ready,
	input wire logic irq_event,
	output logic transceiver_talk_enable,
	output logic controller_active_n,
	output logic atn_drive,
	output logic trigger_out,
	output logic power_on_msg,
	output logic native_mode,
	output logic [ghpi_pkg::DW-1:0] command_data_out_reg,
	output logic out_strobe,
	output logic [ghpi_pkg::DW-1:0] aux_command_reg,
	output logic aux_strobe
);
	import ghpi_pkg::*;
	ghpi_ctl_t ctl_q;
	ghpi_ctl_t ctl_d;
	logic ce_n_s;
	logic [RSW-1:0] rs_s;
	logic data_direction_line_s;
	logic we_n_s;
	logic gr_n_s;
	logic [DW-1:0] hd_s;
	logic we_n_q;
	logic page_q;
	logic swrst_q;
	logic native_q;
	logic trig_q;
	logic req_q;
	logic irq_q;
	logic [DW-1:0] ctrl_q;
	logic [DW-1:0] command_data_out_reg_q;
	logic [DW-1:0] aux_q;
	logic out_stb_q;
	logic aux_stb_q;
	logic [DW-1:0] rdata_q;
	logic rd_q;
	logic [DW-1:0] wreg;
	logic [DW-1:0] stat2;
	logic [DW-1:0] rsel;
	logic grant;
	logic cpu_sel;
	logic we_trail;
	logic cpu_wr;
	logic dma_wr;
	logic dma_rd;
	logic cpu_rd;
	logic wr_aux;
	logic wr_data;
	logic wr_ctrl;
	logic cic;
	logic cpu_rd_q;
	logic rd_end;
	////////////////////////////////////////////////////////////////
	ghpi_sync #(.W(RSW + 4 + DW), .INIT({{RSW{1'b0}}, 4'hf, {DW{1'b0}}})) u_sync
	(
		.clock(clock),
		.resetn(resetn),
		.din({pins.register_select, pins.ce_n, pins.data_direction_line, pins.we_n,
			pins.dma_grant_n, pins.host_data}),
		.dout({rs_s, ce_n_s, data_direction_line_s, we_n_s, gr_n_s, hd_s})
	);
	genvar i;
	generate
		for (i = 0; i < DW; i++)
		begin : g_rev
			assign wreg[i] = hd_s[DW-1-i];
			assign pins.dev_data[i] = rdata_q[DW-1-i];
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	assign grant = !gr_n_s;
	assign cpu_sel = !grant && !ce_n_s;
	assign we_trail = we_n_s && !we_n_q;
	assign cpu_wr = cpu_sel && we_trail && !data_direction_line_s;
	assign dma_wr = grant && we_trail && data_direction_line_s;
	assign cpu_rd = cpu_sel && we_n_s && data_direction_line_s;
	assign dma_rd = grant && we_n_s && !data_direction_line_s;
	// read access ends, page may drop
	assign rd_end = cpu_rd_q && !cpu_rd;
	assign wr_data = cpu_wr && (rs_s == RS_DATA) && !page_q;
	assign wr_aux = cpu_wr && (rs_s == RS_AUX);
	assign wr_ctrl = cpu_wr && (rs_s == RS_CTRL);
	assign cic = (ctl_q != GHPI_IDLE);
	assign stat2 = {{(DW-1){1'b0}}, cic} << STAT2_CIC_BIT;
	assign rsel = (page_q && rs_s == RS_PAGED_ID) ? PAGED_ID_VAL :
		(rs_s == RS_STAT2) ? stat2 :
		(rs_s == RS_CTRL) ? ctrl_q :
		(rs_s == RS_DATA) ? data_in_byte : 8'h00;
	////////////////////////////////////////////////////////////////
	always_comb
	begin
		ctl_d = ctl_q;
		case (ctl_q)
			GHPI_IDLE:
			begin
				if (wr_aux && wreg[6:0] == AUX_SIC && !swrst_q)
					ctl_d = GHPI_ACTIVE;
				else if (control_received)
					ctl_d = GHPI_ACTIVE;
			end
			GHPI_ACTIVE:
			begin
				if (wr_aux && wreg[6:0] == AUX_GTS)
					ctl_d = GHPI_STANDBY;
			end
			GHPI_STANDBY:
			begin
				if (wr_aux && wreg[6:0] == AUX_TCA)
					ctl_d = GHPI_ACTIVE;
			end
			default:
				ctl_d = GHPI_IDLE;
		endcase
		if (ifc_received || swrst_q)
			ctl_d = GHPI_IDLE;
	end
	////////////////////////////////////////////////////////////////
	// async reset state
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl_q <= GHPI_IDLE;
			we_n_q <= 1'b1;
			page_q <= 1'b0;
			swrst_q <= 1'b1;
			native_q <= 1'b1;
			trig_q <= 1'b0;
			ctrl_q <= 8'h00;
			command_data_out_reg_q <= 8'h00;
			aux_q <= 8'h00;
			out_stb_q <= 1'b0;
			aux_stb_q <= 1'b0;
			rdata_q <= 8'h00;
			rd_q <= 1'b0;
			cpu_rd_q <= 1'b0;
		end
		else
		begin
			ctl_q <= ctl_d;
			we_n_q <= we_n_s;
			out_stb_q <= wr_data || dma_wr;
			aux_stb_q <= wr_aux;
			rd_q <= cpu_rd || dma_rd;
			cpu_rd_q <= cpu_rd;
			// grant routes DMA to data registers
			if (dma_rd)
				rdata_q <= data_in_byte;
			else if (cpu_rd)
				rdata_q <= rsel;
			if (wr_data || dma_wr)
				command_data_out_reg_q <= wreg;
			if (wr_ctrl)
				ctrl_q <= wreg;
			if (wr_aux)
				aux_q <= wreg;
			if (wr_aux && wreg[6:0] == AUX_PAGE)
				page_q <= 1'b1;
			else if (rd_end || cpu_wr)
				page_q <= 1'b0;
			if (wr_aux && wreg[6:0] == AUX_SWRST)
				swrst_q <= wreg[AUX_SET_BIT];
			if (wr_aux && wreg[6:0] == AUX_MODE7)
				native_q <= !wreg[AUX_SET_BIT];
			trig_q <= wr_aux && wreg[6:0] == AUX_TRIG;
		end
	end
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			req_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			req_q <= ctrl_q[CTRL_DMAEN_BIT] && !grant && (data_in_valid || out_ready);
			irq_q <= irq_event;
		end
	end
	////////////////////////////////////////////////////////////////
	// talk enable
	assign transceiver_talk_enable = (parallel_poll_active && !cic) || !source_idle;
	assign controller_active_n = !cic;
	assign atn_drive = (ctl_q == GHPI_ACTIVE);
	assign trigger_out = device_trigger_active || trig_q;
	assign power_on_msg = swrst_q;
	assign native_mode = native_q;
	assign command_data_out_reg = command_data_out_reg_q;
	assign out_strobe = out_stb_q;
	assign aux_command_reg = aux_q;
	assign aux_strobe = aux_stb_q;
	assign pins.dev_data_oe = rd_q && (cpu_rd || dma_rd);
	assign pins.dma_request_n = !req_q;
	assign pins.int_out = 1'b0;
	assign pins.int_oe = irq_q;
endmodule : ghpi_device
`default_nettype wire

// ===== core/ghpi_pkg.sv
// Purpose: shared constants for the host pin interface
// Assumes: 8-bit data, 3-bit register select
// Notes: aux command codes and page map are local choices
package ghpi_pkg;
	localparam int DW = 8;
	localparam int RSW = 3;
	// register select values, page 0 and page 1
	localparam logic [2:0] RS_DATA = 3'h7;
	localparam logic [2:0] RS_AUX = 3'h3;
	localparam logic [2:0] RS_STAT2 = 3'h1;
	localparam logic [2:0] RS_CTRL = 3'h2;
	localparam logic [2:0] RS_PAGED_ID = 3'h7;
	// aux command codes (bit 7 is set/clear for some)
	localparam logic [6:0] AUX_SWRST = 7'h00;
	localparam logic [6:0] AUX_TRIG = 7'h08;
	localparam logic [6:0] AUX_GTS = 7'h0b;
	localparam logic [6:0] AUX_TCA = 7'h0c;
	localparam logic [6:0] AUX_SIC = 7'h0f;
	localparam logic [6:0] AUX_PAGE = 7'h1d;
	localparam logic [6:0] AUX_MODE7 = 7'h15;
	localparam logic [6:0] AUX_RPP = 7'h0e;
	localparam int AUX_SET_BIT = 7;
	localparam int STAT2_CIC_BIT = 0;
	localparam logic [7:0] PAGED_ID_VAL = 8'h5a;
	// control register bits
	localparam int CTRL_SIDS_BIT = 0;
	localparam int CTRL_DMAEN_BIT = 1;
	typedef enum logic [1:0]
	{
		GHPI_IDLE = 2'b00,
		GHPI_ACTIVE = 2'b01,
		GHPI_STANDBY = 2'b10
	} ghpi_ctl_t;
	typedef enum logic [1:0]
	{
		GHPI_H_IDLE = 2'b00,
		GHPI_H_SETUP = 2'b01,
		GHPI_H_STROBE = 2'b10,
		GHPI_H_DONE = 2'b11
	} ghpi_hst_t;
endpackage : ghpi_pkg

// ===== core/ghpi_if.sv
// Purpose: pin bundle between host and device
// Assumes: testbench resolves open-collector interrupt
// Notes: pin-order data bus, bit reversed vs registers
`timescale 1ns/1ps
`default_nettype none
interface ghpi_if;
	import ghpi_pkg::*;
	logic ce_n;
	logic [RSW-1:0] register_select;
	logic data_direction_line;
	logic we_n;
	logic dma_grant_n;
	logic dma_request_n;
	logic [DW-1:0] host_data;
	logic [DW-1:0] dev_data;
	logic dev_data_oe;
	logic int_out;
	logic int_oe;
	modport dev
	(
		input ce_n, register_select, data_direction_line, we_n, dma_grant_n, host_data,
		output dma_request_n, dev_data, dev_data_oe, int_out, int_oe
	);
	modport host
	(
		output ce_n, register_select, data_direction_line, we_n, dma_grant_n, host_data,
		input dma_request_n, dev_data, dev_data_oe, int_out, int_oe
	);
endinterface : ghpi_if
`default_nettype wire

// ===== core/ghpi_sync.sv
// Purpose: three-stage input synchroniser with agreement
// Assumes: single clock
// Notes: output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ghpi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;
	logic [W-1:0] out_d;
	if (W < 1)
	begin : g_bad_w
		$error("W must be at least 1");
	end
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_agree
			assign out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
		end
	endgenerate
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			out_q <= INIT;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end
	assign dout = out_q;
endmodule : ghpi_sync
`default_nettype wire

// ===== core/ghpi_host.sv
// Purpose: host CPU / DMA end driving the device pins
// Assumes: device samples pins through synchronisers
// Notes: each phase lasts HOLD+1 cycles to cover sync delay
`timescale 1ns/1ps
`default_nettype none
module ghpi_host
	import ghpi_pkg::*;
#(
	parameter int HOLD = 6
)
(
	input wire logic clock,
	input wire logic resetn,
	ghpi_if.host pins,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_dma,
	input wire logic [ghpi_pkg::RSW-1:0] req_addr,
	input wire logic [ghpi_pkg::DW-1:0] req_wdata,
	output logic req_ready,
	output logic [ghpi_pkg::DW-1:0] rsp_rdata,
	output logic rsp_valid,
	output logic dma_wanted
);
	import ghpi_pkg::*;
	if (HOLD < 4 || HOLD > 255)
	begin : g_bad_hold
		$error("HOLD out of range");
	end
	ghpi_hst_t st_q;
	ghpi_hst_t st_d;
	logic [7:0] cnt_q;
	logic wr_q;
	logic dma_q;
	logic [RSW-1:0] addr_q;
	logic [DW-1:0] wd_q;
	logic [DW-1:0] rd_q;
	logic rv_q;
	logic [DW-1:0] pin_wd;
	logic [DW-1:0] pin_rd;
	logic cnt_done;
	logic rq_s;
	assign cnt_done = (cnt_q == 8'(HOLD));
	ghpi_sync #(.W(1), .INIT(1'b1)) u_rq
	(
		.clock(clock),
		.resetn(resetn),
		.din(pins.dma_request_n),
		.dout(rq_s)
	);
	genvar i;
	generate
		for (i = 0; i < DW; i++)
		begin : g_rev
			assign pin_wd[i] = wd_q[DW-1-i];
			assign pin_rd[i] = pins.dev_data[DW-1-i];
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			GHPI_H_IDLE:
				if (req_valid)
					st_d = GHPI_H_SETUP;
			GHPI_H_SETUP:
				if (cnt_done)
					st_d = GHPI_H_STROBE;
			GHPI_H_STROBE:
				if (cnt_done)
					st_d = GHPI_H_DONE;
			GHPI_H_DONE:
				if (cnt_done)
					st_d = GHPI_H_IDLE;
			default:
				st_d = GHPI_H_IDLE;
		endcase
	end
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= GHPI_H_IDLE;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			dma_q <= 1'b0;
			addr_q <= 3'h0;
			wd_q <= 8'h00;
			rd_q <= 8'h00;
			rv_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= (st_d != st_q) ? 8'h00 : cnt_q + 8'h01;
			rv_q <= 1'b0;
			if (st_q == GHPI_H_IDLE && req_valid)
			begin
				wr_q <= req_write;
				dma_q <= req_dma;
				addr_q <= req_addr;
				wd_q <= req_wdata;
			end
			if (st_q == GHPI_H_STROBE && cnt_done && !wr_q)
			begin
				rd_q <= pin_rd;
				rv_q <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	assign req_ready = (st_q == GHPI_H_IDLE);
	assign rsp_rdata = rd_q;
	assign rsp_valid = rv_q;
	assign dma_wanted = !rq_s;
	assign pins.dma_grant_n = !(dma_q && st_q != GHPI_H_IDLE);
	assign pins.ce_n = !(!dma_q && st_q != GHPI_H_IDLE);
	assign pins.register_select = addr_q;
	assign pins.data_direction_line = (st_q != GHPI_H_IDLE) && (wr_q == dma_q);
	assign pins.we_n = !(wr_q && st_q == GHPI_H_STROBE);
	assign pins.host_data = pin_wd;
endmodule : ghpi_host
`default_nettype wire

// ===== tb/ghpi_checker.sv
// Purpose: pin protocol checks
// Assumes: one clock, both ends are design
// Notes: sees only the shared pin bundle
`timescale 1ns/1ps
`default_nettype none
module ghpi_checker
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce_n,
	input wire logic [2:0] register_select,
	input wire logic data_direction_line,
	input wire logic we_n,
	input wire logic dma_grant_n,
	input wire logic dma_request_n,
	input wire logic [7:0] host_data,
	input wire logic dev_data_oe,
	input wire logic int_out
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	a_int_low:
	assert property (int_out == 1'b0) else $error("interrupt pin driven high");
	a_grant_drops_req:
	assert property ($fell(dma_grant_n) |-> ##[0:6] dma_request_n) else $error("request kept");
	a_grant_holds_req:
	assert property ((!dma_grant_n)[*8] |-> dma_request_n) else $error("request under grant");
	a_read_strobe_idle:
	assert property ((!ce_n && dma_grant_n && data_direction_line) |-> we_n)
		else $error("strobe in read");
	a_dma_write_dir:
	assert property ((!dma_grant_n && !we_n) |-> data_direction_line) else $error("dma dir low");
	a_strobe_stable:
	assert property ((!we_n && !$past(we_n)) |-> $stable(host_data)
		&& $stable(register_select) && $stable(data_direction_line)) else $error("moved in strobe");
	a_strobe_after_sel:
	assert property ($fell(we_n) |-> (!$past(ce_n) || !$past(dma_grant_n)))
		else $error("strobe unselected");
	a_oe_on_read:
	assert property ($rose(dev_data_oe) |-> (dma_grant_n ? (!ce_n && data_direction_line)
		: !data_direction_line)) else $error("drive without read");
endmodule : ghpi_checker
`default_nettype wire

// ===== tb/gpib_host_pin_interface_tb.sv
// Purpose: bench joining host and device ends
// Assumes: request words in register bit order
// Notes: seed 79
`timescale 1ns/1ps
`default_nettype none
module gpib_host_pin_interface_tb;
	import ghpi_pkg::*;
	logic clock = 0;
	logic resetn = 0;
	logic pp = 0, sid = 1, dta = 0, ifc = 0, div = 0, ordy = 0, irq = 0;
	logic rv = 0, rw = 0, rd = 0, rr, dw, te, can, atn, trg, pon, nat, os, as, rsv, crx = 0;
	logic [2:0] ra = 0;
	logic [7:0] dib = 0, wd = 0, x, y, z, rdat, cdo, acr;
	int errors = 0, total_checks = 0, seed = 79, trigs = 0, t;
	int outs = 0, auxs = 0, rvs = 0;
	ghpi_if bus ();
	ghpi_device ghpi_device_inst (.clock(clock), .resetn(resetn), .pins(bus.dev),
		.parallel_poll_active(pp), .source_idle(sid), .device_trigger_active(dta),
		.ifc_received(ifc), .control_received(crx), .data_in_byte(dib),
		.data_in_valid(div), .out_ready(ordy), .irq_event(irq),
		.transceiver_talk_enable(te), .controller_active_n(can), .atn_drive(atn),
		.trigger_out(trg), .power_on_msg(pon), .native_mode(nat),
		.command_data_out_reg(cdo), .out_strobe(os), .aux_command_reg(acr), .aux_strobe(as));
	ghpi_host ghpi_host_inst (.clock(clock), .resetn(resetn), .pins(bus.host),
		.req_valid(rv), .req_write(rw), .req_dma(rd), .req_addr(ra), .req_wdata(wd),
		.req_ready(rr), .rsp_rdata(rdat), .rsp_valid(rsv), .dma_wanted(dw));
	ghpi_checker ghpi_checker_inst (.clock(clock), .resetn(resetn), .ce_n(bus.ce_n),
		.register_select(bus.register_select), .data_direction_line(bus.data_direction_line),
		.we_n(bus.we_n), .dma_grant_n(bus.dma_grant_n), .dma_request_n(bus.dma_request_n),
		.host_data(bus.host_data), .dev_data_oe(bus.dev_data_oe), .int_out(bus.int_out));
	always #25 clock = ~clock;
	always @(posedge clock)
	begin
		trigs <= trigs + int'(trg);
		outs <= outs + int'(os);
		auxs <= auxs + int'(as);
		rvs <= rvs + int'(rsv);
	end
	////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : cyc
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev[i] = v[7-i];
	endfunction : rev
	task automatic xfer(input logic w, input logic d, input logic [2:0] a, input logic [7:0] v);
		int n, o0, a0, r0;
		n = 0;
		o0 = outs;
		a0 = auxs;
		r0 = rvs;
		y = ~rev(v);
		rv = 1;
		rw = w;
		rd = d;
		ra = a;
		wd = v;
		cyc(1);
		rv = 0;
		while (rr !== 1'b1 && n < 200)
		begin
			if (bus.we_n === 1'b0)
				y = bus.host_data;
			cyc(1);
			n++;
		end
		// transfer never finished
		if (rr !== 1'b1)
			chk(8'h00, 8'h01);
		// pin order reversed
		if (w)
			chk(y, rev(v));
		else
			chk(8'(rvs - r0), 8'h01);
		cyc(2);
		chk(8'(outs - o0), {7'h0, w & (d | (a == RS_DATA))});
		chk(8'(auxs - a0), {7'h0, w & ~d & (a == RS_AUX)});
	endtask : xfer
	task automatic aux(input logic [7:0] c);
		xfer(1, 0, RS_AUX, c);
	endtask : aux
	task automatic te_loop(input logic cic);
		repeat (6)
		begin
			x = 8'($random(seed));
			pp = x[0];
			sid = x[1];
			cyc(1);
			chk({7'h0, te}, {7'h0, (x[0] & ~cic) | ~x[1]});
		end
		sid = 1;
	endtask : te_loop
	task automatic stat2(input logic cic);
		xfer(0, 0, RS_STAT2, 8'h00);
		chk({7'h0, rdat[STAT2_CIC_BIT]}, {7'h0, cic});
	endtask : stat2
	////////////////////////////////////////
	initial
	begin
		#1000000;
		errors++;
		give_verdict();
	end
	initial
	begin
		cyc(8);
		resetn = 1;
		chk({4'h0, can, atn, pon, nat}, 8'h0b);
		te_loop(1'b0);
		$display("reset and talk enable done");
		aux({1'b0, AUX_SIC});
		chk({7'h0, can}, 8'h01);
		aux({1'b0, AUX_SWRST});
		chk({7'h0, pon}, 8'h00);
		aux({1'b0, AUX_SIC});
		chk({6'h0, can, atn}, 8'h01);
		te_loop(1'b1);
		stat2(1'b1);
		aux({1'b0, AUX_GTS});
		chk({6'h0, can, atn}, 8'h00);
		stat2(1'b1);
		aux({1'b0, AUX_TCA});
		chk({6'h0, can, atn}, 8'h01);
		ifc = 1;
		cyc(1);
		ifc = 0;
		cyc(6);
		chk({7'h0, can}, 8'h01);
		stat2(1'b0);
		crx = 1;
		cyc(1);
		crx = 0;
		cyc(2);
		chk({6'h0, can, atn}, 8'h01);
		$display("controller states done");
		for (int i = 0; i < 8; i++)
		begin
			x = (i < 2) ? {8{i[0]}} : 8'($random(seed));
			xfer(1, 0, RS_DATA, x);
			chk(cdo, x);
			dib = ~x;
			div = 1;
			xfer(0, 0, RS_DATA, 8'h00);
			chk(rdat, ~x);
			xfer(0, 1, RS_AUX, 8'h00);
			chk(rdat, ~x);
			z = acr;
			xfer(1, 1, RS_AUX, x + 8'h01);
			chk(cdo, x + 8'h01);
			chk(acr, z);
		end
		aux({1'b0, AUX_PAGE});
		xfer(0, 0, RS_DATA, 8'h00);
		chk(rdat, PAGED_ID_VAL);
		$display("data paths done");
		xfer(1, 0, RS_CTRL, 8'h02);
		ordy = 1;
		cyc(8);
		chk({7'h0, dw}, 8'h01);
		xfer(1, 1, RS_DATA, 8'h3c);
		ordy = 0;
		t = trigs;
		aux({1'b0, AUX_TRIG});
		chk(8'(trigs - t), 8'h01);
		aux({1'b1, AUX_MODE7});
		chk({7'h0, nat}, 8'h00);
		t = trigs;
		aux({1'b0, AUX_TRIG});
		chk(8'(trigs - t), 8'h01);
		dta = 1;
		cyc(6);
		chk({7'h0, trg}, 8'h01);
		dta = 0;
		irq = 1;
		cyc(3);
		chk({6'h0, bus.int_oe, bus.int_out}, 8'h02);
		irq = 0;
		$display("dma trigger interrupt done");
		resetn = 0;
		#1;
		chk({5'h0, can, pon, nat}, 8'h07);
		cyc(2);
		resetn = 1;
		cyc(2);
		chk({6'h0, pon, nat}, 8'h03);
		stat2(1'b0);
		$display("async reset done");
		give_verdict();
	end
endmodule : gpib_host_pin_interface_tb
`default_nettype wire
